// ===== cdid_pkg.sv
package cdid_pkg;
   // opcode classes by leading one
   typedef enum logic [3:0] {
      CDID_OP_NONE = 4'h0,
      CDID_OP_CLEAR = 4'h1,
      CDID_OP_HOME = 4'h2,
      CDID_OP_ENTRY = 4'h3,
      CDID_OP_DISP = 4'h4,
      CDID_OP_SHIFT = 4'h5,
      CDID_OP_MODE = 4'h6,
      CDID_OP_FUNC = 4'h7,
      CDID_OP_GLYPH_ADDR = 4'h8,
      CDID_OP_DDATA_ADDR = 4'h9,
      CDID_OP_DATA_WR = 4'hA,
      CDID_OP_DATA_RD = 4'hB
   } cdid_op_t;

   typedef enum logic [1:0] {
      CDID_ST_IDLE = 2'b00,
      CDID_ST_CLEAR = 2'b01,
      CDID_ST_BUSY = 2'b10,
      CDID_ST_ADDR_UPD = 2'b11
   } cdid_state_t;

   localparam logic [7:0] CDID_BLANK_CODE = 8'h20;
   localparam int CDID_CLK_KHZ = 125000;
   localparam int CDID_CLEAR_TIME_US = 6200;
   localparam int CDID_CLEAR_CYC = (CDID_CLEAR_TIME_US * CDID_CLK_KHZ) / 1000;
   localparam int CDID_EXEC_TIME_NS = 40;
   localparam int CDID_EXEC_CYC =
      (CDID_EXEC_TIME_NS * CDID_CLK_KHZ + 999999) / 1000000;
   localparam int CDID_ADD_TIME_NS = 8;
   localparam int CDID_ADD_CYC =
      (CDID_ADD_TIME_NS * CDID_CLK_KHZ + 999999) / 1000000;
   localparam logic [1:0] CDID_FONT_DEFAULT = 2'h0;
   localparam logic [1:0] CDID_FONT_INVALID = 2'h3;
   localparam logic [1:0] CDID_MODE_SUFFIX = 2'h3;
   localparam logic [1:0] CDID_SHIFT_SUFFIX = 2'h0;
   localparam logic CDID_ENTRY_INC_RST = 1'b1;
   localparam logic CDID_BUS8_RST = 1'b1;
endpackage : cdid_pkg

// ===== cdid_decode.sv
`timescale 1ns/1ps
module cdid_decode
   import cdid_pkg::*;
(
   input wire logic reg_select,
   input wire logic read_not_write,
   input wire logic [7:0] code,
   output cdid_op_t op
);
   always_comb begin
      op = CDID_OP_NONE;
      if (reg_select && !read_not_write) begin
         op = CDID_OP_DATA_WR;
      end else if (reg_select) begin
         op = CDID_OP_DATA_RD;
      end else if (read_not_write) begin
         op = CDID_OP_NONE;
      end else if (code[7]) begin
         op = CDID_OP_DDATA_ADDR;
      end else if (code[6]) begin
         op = CDID_OP_GLYPH_ADDR;
      end else if (code[5]) begin
         op = CDID_OP_FUNC;
      end else if (code[4]) begin
         if (code[1:0] == CDID_MODE_SUFFIX) begin
            op = CDID_OP_MODE;
         end else if (code[1:0] == CDID_SHIFT_SUFFIX) begin
            op = CDID_OP_SHIFT;
         end
      end else if (code[3]) begin
         op = CDID_OP_DISP;
      end else if (code[2]) begin
         op = CDID_OP_ENTRY;
      end else if (code[1]) begin
         op = CDID_OP_HOME;
      end else if (code[0]) begin
         op = CDID_OP_CLEAR;
      end
   end
endmodule : cdid_decode

// ===== cdid_core.sv
`timescale 1ns/1ps
// How it works
// - two registers, select and direction chosen
// - while busy only status read accepted
// - busy high through execution, low after
// - clear fills display RAM with blank
// - clear homes counter, forces increment
// - home zeroes counter and display shift
// - entry mode loads direction and shift
// - display control stores three bits
// - shift moves cursor or display once
// - mode form stores graphic select
// - mode form stores internal power bit
// - function set stores width, lines, font
// - lines and font bit meanings
// - glyph address load targets glyph RAM
// - display address load targets display RAM
// - status read gives busy and counter
// - data access hits selected RAM
// - counter steps after each data access
// - counter updates after busy release
// - shift enable shifts display on display RAM write
// - narrow bus moves byte in halves
// - font table select, default zero
// - display shift keeps counter, cursor moves
// - shift left on increment, right otherwise
module cdid_core
   import cdid_pkg::*;
#(
   parameter int DDATA_DEPTH = 128,
   parameter int GLYPH_DEPTH = 64,
   parameter int CLEAR_CYC = CDID_CLEAR_CYC
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic strobe,
   input wire logic reg_select,
   input wire logic read_not_write,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out_q,
   output logic data_valid_q,
   output logic busy_flag_q,
   output logic [6:0] ram_address_counter_q,
   output logic display_on_q,
   output logic cursor_on_q,
   output logic blink_on_q,
   output logic entry_inc_q,
   output logic entry_shift_q,
   output logic graphic_mode_q,
   output logic power_on_q,
   output logic bus_width_sel_q,
   output logic two_lines_q,
   output logic tall_font_q,
   output logic font_table_hi_q,
   output logic font_table_lo_q,
   output logic signed [7:0] display_shift_q,
   output logic invalid_q
);
   if (DDATA_DEPTH < 1 || DDATA_DEPTH > 128 || GLYPH_DEPTH < 1 ||
       GLYPH_DEPTH > 64 || CLEAR_CYC < DDATA_DEPTH) begin : g_bad_cfg
      $error("cdid_core: unsupported parameters");
   end
   logic [7:0] ddata_mem [DDATA_DEPTH];
   logic [7:0] glyph_mem [GLYPH_DEPTH];
   // synchronisers for pin inputs
   logic strobe_m, strobe_s, strobe_p;
   logic rs_m, rs_s, rw_m, rw_s;
   logic [7:0] din_m, din_s;
   logic half_q, target_glyph_q, step_pend_q, byte_ok;
   logic [3:0] hi_nib_q;
   logic [22:0] cnt_q;
   cdid_state_t state_q;
   cdid_op_t op;
   logic [7:0] byte_w;
   logic [6:0] ac_step;
   always_ff @(posedge clk) begin
      if (rst) begin
         strobe_m <= 1'b0;
         strobe_s <= 1'b0;
         strobe_p <= 1'b0;
         rs_m <= 1'b0;
         rs_s <= 1'b0;
         rw_m <= 1'b0;
         rw_s <= 1'b0;
         din_m <= 8'h00;
         din_s <= 8'h00;
      end else if (ce) begin
         strobe_m <= strobe;
         strobe_s <= strobe_m;
         strobe_p <= strobe_s;
         rs_m <= reg_select;
         rs_s <= rs_m;
         rw_m <= read_not_write;
         rw_s <= rw_m;
         din_m <= data_in;
         din_s <= din_m;
      end
   end
   wire take = strobe_s && !strobe_p;
   always_ff @(posedge clk) begin
      if (rst) begin
         half_q <= 1'b0;
         hi_nib_q <= 4'h0;
      end else if (ce && take && !bus_width_sel_q) begin
         half_q <= !half_q;
         if (!half_q) begin
            hi_nib_q <= din_s[7:4];
         end
      end
   end
   assign byte_ok = take && (bus_width_sel_q || half_q);
   assign byte_w = bus_width_sel_q ? din_s : {hi_nib_q, din_s[7:4]};
   cdid_decode u_dec (
      .reg_select(rs_s),
      .read_not_write(rw_s),
      .code(byte_w),
      .op(op)
   );
   assign ac_step = entry_inc_q ? ram_address_counter_q + 7'h01 :
                    ram_address_counter_q - 7'h01;
   wire accept = ce && byte_ok && state_q == CDID_ST_IDLE &&
                 !step_pend_q;
   wire status_rd = byte_ok && !rs_s && rw_s;
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= CDID_ST_IDLE;
         cnt_q <= '0;
         busy_flag_q <= 1'b0;
         step_pend_q <= 1'b0;
         invalid_q <= 1'b0;
      end else if (ce) begin
         invalid_q <= byte_ok && !status_rd && !accept;
         case (state_q)
            CDID_ST_IDLE: begin
               if (accept && op == CDID_OP_CLEAR) begin
                  state_q <= CDID_ST_CLEAR;
                  busy_flag_q <= 1'b1;
                  cnt_q <= '0;
               end else if (accept && op != CDID_OP_NONE) begin
                  state_q <= CDID_ST_BUSY;
                  busy_flag_q <= 1'b1;
                  cnt_q <= 23'(CDID_EXEC_CYC - 1);
                  step_pend_q <= op == CDID_OP_DATA_WR ||
                                 op == CDID_OP_DATA_RD;
               end
            end
            CDID_ST_CLEAR: begin
               if (cnt_q == 23'(CLEAR_CYC - 1)) begin
                  state_q <= CDID_ST_IDLE;
                  busy_flag_q <= 1'b0;
               end else begin
                  cnt_q <= cnt_q + 23'h000001;
               end
            end
            CDID_ST_BUSY: begin
               if (cnt_q == '0) begin
                  busy_flag_q <= 1'b0;
                  state_q <= step_pend_q ? CDID_ST_ADDR_UPD : CDID_ST_IDLE;
                  cnt_q <= 23'(CDID_ADD_CYC - 1);
               end else begin
                  cnt_q <= cnt_q - 23'h000001;
               end
            end
            CDID_ST_ADDR_UPD: begin
               if (cnt_q == '0) begin
                  state_q <= CDID_ST_IDLE;
                  step_pend_q <= 1'b0;
               end else begin
                  cnt_q <= cnt_q - 23'h000001;
               end
            end
            default: state_q <= CDID_ST_IDLE;
         endcase
      end
   end
   // blank fill, one location a cycle
   always_ff @(posedge clk) begin
      if (ce && state_q == CDID_ST_CLEAR && cnt_q < 23'(DDATA_DEPTH)) begin
         ddata_mem[cnt_q[6:0]] <= CDID_BLANK_CODE;
      end else if (accept && op == CDID_OP_DATA_WR && !target_glyph_q) begin
         ddata_mem[ram_address_counter_q] <= byte_w;
      end
   end
   always_ff @(posedge clk) begin
      if (accept && op == CDID_OP_DATA_WR && target_glyph_q) begin
         glyph_mem[ram_address_counter_q[5:0]] <= byte_w;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         data_out_q <= 8'h00;
         data_valid_q <= 1'b0;
      end else if (ce) begin
         data_valid_q <= status_rd || (accept && op == CDID_OP_DATA_RD);
         if (status_rd) begin
            data_out_q <= {busy_flag_q, ram_address_counter_q};
         end else if (accept && op == CDID_OP_DATA_RD) begin
            data_out_q <= target_glyph_q ?
               glyph_mem[ram_address_counter_q[5:0]] :
               ddata_mem[ram_address_counter_q];
         end
      end
   end

   // address counter and target select
   always_ff @(posedge clk) begin
      if (rst) begin
         ram_address_counter_q <= 7'h00;
         target_glyph_q <= 1'b0;
      end else if (ce) begin
         if (state_q == CDID_ST_ADDR_UPD && cnt_q == '0) begin
            ram_address_counter_q <= ac_step;
         end else if (accept) begin
            case (op)
               CDID_OP_CLEAR, CDID_OP_HOME: begin
                  ram_address_counter_q <= 7'h00;
                  target_glyph_q <= 1'b0;
               end
               CDID_OP_SHIFT: begin
                  if (!byte_w[3]) begin
                     ram_address_counter_q <= byte_w[2] ?
                        ram_address_counter_q + 7'h01 :
                        ram_address_counter_q - 7'h01;
                  end
               end
               CDID_OP_GLYPH_ADDR: begin
                  ram_address_counter_q <= {1'b0, byte_w[5:0]};
                  target_glyph_q <= 1'b1;
               end
               CDID_OP_DDATA_ADDR: begin
                  ram_address_counter_q <= byte_w[6:0];
                  target_glyph_q <= 1'b0;
               end
               default: ;
            endcase
         end
      end
   end

   // display shift offset
   always_ff @(posedge clk) begin
      if (rst) begin
         display_shift_q <= 8'sh00;
      end else if (accept) begin
         if (op == CDID_OP_CLEAR || op == CDID_OP_HOME) begin
            display_shift_q <= 8'sh00;
         end else if (op == CDID_OP_SHIFT && byte_w[3]) begin
            display_shift_q <= byte_w[2] ? display_shift_q + 8'sh01 :
                               display_shift_q - 8'sh01;
         end else if (op == CDID_OP_DATA_WR && entry_shift_q &&
                      !target_glyph_q) begin
            display_shift_q <= entry_inc_q ? display_shift_q - 8'sh01 :
                               display_shift_q + 8'sh01;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk) begin
      if (rst) begin
         entry_inc_q <= CDID_ENTRY_INC_RST;
         entry_shift_q <= 1'b0;
         display_on_q <= 1'b0;
         cursor_on_q <= 1'b0;
         blink_on_q <= 1'b0;
         graphic_mode_q <= 1'b0;
         power_on_q <= 1'b0;
         bus_width_sel_q <= CDID_BUS8_RST;
         two_lines_q <= 1'b0;
         tall_font_q <= 1'b0;
         {font_table_hi_q, font_table_lo_q} <= CDID_FONT_DEFAULT;
      end else if (accept) begin
         case (op)
            CDID_OP_CLEAR: entry_inc_q <= 1'b1;
            CDID_OP_ENTRY: begin
               entry_inc_q <= byte_w[1];
               entry_shift_q <= byte_w[0];
            end
            CDID_OP_DISP: begin
               display_on_q <= byte_w[2];
               cursor_on_q <= byte_w[1];
               blink_on_q <= byte_w[0];
            end
            CDID_OP_MODE: begin
               graphic_mode_q <= byte_w[3];
               power_on_q <= byte_w[2];
            end
            CDID_OP_FUNC: begin
               bus_width_sel_q <= byte_w[4];
               two_lines_q <= byte_w[3];
               tall_font_q <= byte_w[2];
               if (byte_w[1:0] != CDID_FONT_INVALID) begin
                  {font_table_hi_q, font_table_lo_q} <= byte_w[1:0];
               end
            end
            default: ;
         endcase
      end
   end
   AST_BUSY_HELD: assert property (@(posedge clk) disable iff (rst)
      (state_q == CDID_ST_CLEAR || state_q == CDID_ST_BUSY) |-> busy_flag_q)
      else $error("busy low during execution");
   AST_CLEAR_BUSY: assert property (@(posedge clk) disable iff (rst)
      (accept && op == CDID_OP_CLEAR) |=> busy_flag_q)
      else $error("clear did not set busy");
   AST_HOME_AC: assert property (@(posedge clk) disable iff (rst)
      (accept && op == CDID_OP_HOME) |=> ram_address_counter_q == 7'h00)
      else $error("home did not zero counter");
   AST_CLEAR_INC: assert property (@(posedge clk) disable iff (rst)
      (accept && op == CDID_OP_CLEAR) |=>
         entry_inc_q && $stable(entry_shift_q))
      else $error("clear entry bits wrong");
   AST_NO_ACCEPT_BUSY: assert property (@(posedge clk) disable iff (rst)
      busy_flag_q |-> !accept)
      else $error("accepted while busy");
   AST_STATUS: assert property (@(posedge clk) disable iff (rst)
      (ce && status_rd) |=> data_valid_q &&
         data_out_q == {$past(busy_flag_q), $past(ram_address_counter_q)})
      else $error("status read wrong");
   AST_AC_LATE: assert property (@(posedge clk) disable iff (rst)
      $fell(busy_flag_q) && step_pend_q |-> $stable(ram_address_counter_q))
      else $error("counter moved with busy release");
   AST_GLYPH_ADDR: assert property (@(posedge clk) disable iff (rst)
      (accept && op == CDID_OP_GLYPH_ADDR) |=> target_glyph_q &&
         ram_address_counter_q == {1'b0, $past(byte_w[5:0])})
      else $error("glyph address load wrong");
   AST_DISP_SHIFT_AC: assert property (@(posedge clk) disable iff (rst)
      (accept && op == CDID_OP_SHIFT && byte_w[3]) |=>
         $stable(ram_address_counter_q))
      else $error("display shift moved counter");
   AST_FONT_VALID: assert property (@(posedge clk) disable iff (rst)
      {font_table_hi_q, font_table_lo_q} != CDID_FONT_INVALID)
      else $error("invalid font table stored");
   COV_CLEAR: cover property (@(posedge clk) disable iff (rst)
      state_q == CDID_ST_CLEAR ##1 state_q == CDID_ST_IDLE);
   COV_WRITE: cover property (@(posedge clk) disable iff (rst)
      accept && op == CDID_OP_DATA_WR);
   COV_INVALID: cover property (@(posedge clk) disable iff (rst) invalid_q);
endmodule : cdid_core

// ===== cdid_host_model.sv
`timescale 1ns/1ps
module cdid_host_model (
   input wire logic clk,
   input wire logic busy_flag_q,
   input wire logic data_valid_q,
   input wire logic invalid_q,
   input wire logic bus_width_sel_q,
   input wire logic [7:0] data_out_q,
   output logic strobe,
   output logic reg_select,
   output logic read_not_write,
   output logic [7:0] data_in
);
   logic timed_out;
   logic refused;
   logic [7:0] rd;

   initial begin
      strobe = 1'b0;
      reg_select = 1'b0;
      read_not_write = 1'b0;
      data_in = 8'h00;
      timed_out = 1'b0;
      refused = 1'b0;
      rd = 8'h00;
   end

   // one pin transfer; lines held until the answer shows, or five cycles for a half that is not last
   task automatic half(input logic rs, input logic rnw,
         input logic [7:0] d, input logic last);
      logic b0;
      logic done;
      @(posedge clk);
      #1;
      reg_select = rs;
      read_not_write = rnw;
      data_in = d;
      // pins pass a two-stage sync, so settle first
      repeat (3) @(posedge clk);
      #1;
      strobe = 1'b1;
      b0 = busy_flag_q;
      done = 1'b0;
      if (!last) begin
         repeat (5) @(posedge clk);
         done = 1'b1;
      end
      for (int i = 0; i < 12 && !done; i++) begin
         @(posedge clk);
         #1;
         if (data_valid_q === 1'b1) rd = data_out_q;
         if (invalid_q === 1'b1) refused = 1'b1;
         done = data_valid_q === 1'b1 || invalid_q === 1'b1 ||
            (!rnw && busy_flag_q === 1'b1 && b0 !== 1'b1);
      end
      if (!done) timed_out = 1'b1;
      @(posedge clk);
      #1;
      strobe = 1'b0;
      @(posedge clk);
      #1;
      // released bus shows no stale value
      data_in = ~d;
   endtask : half

   task automatic xfer(input logic rs, input logic rnw, input logic [7:0] d);
      refused = 1'b0;
      rd = 8'hXX;
      // narrow bus sends high nibble then low
      if (bus_width_sel_q === 1'b0) begin
         half(rs, rnw, {d[7:4], 4'h0}, 1'b0);
         half(rs, rnw, {d[3:0], 4'h0}, 1'b1);
      end else begin
         half(rs, rnw, d, 1'b1);
      end
   endtask : xfer

   task automatic wait_ready();
      int n;
      n = 0;
      while (busy_flag_q !== 1'b0 && n < 1000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 1000) timed_out = 1'b1;
      // counter lands a little after busy drops
      repeat (2) @(posedge clk);
      #1;
   endtask : wait_ready
endmodule : cdid_host_model

// ===== char_display_instruction_decoder_test.sv
`timescale 1ns/1ps
module char_display_instruction_decoder_test;
   import cdid_pkg::*;
   localparam int CLR_CYC = 200;
   logic clk, rst, ce, strobe, reg_select, read_not_write;
   logic [7:0] data_in, data_out_q;
   logic data_valid_q, busy_flag_q, invalid_q;
   logic [6:0] ram_address_counter_q;
   logic display_on_q, cursor_on_q, blink_on_q, entry_inc_q, entry_shift_q;
   logic graphic_mode_q, power_on_q, bus_width_sel_q, two_lines_q;
   logic tall_font_q, font_table_hi_q, font_table_lo_q;
   logic signed [7:0] display_shift_q;
   int failures, compares;
   logic [7:0] cfg, fnc;
   logic [7:0] sc[4] = '{8'h10, 8'h14, 8'h18, 8'h1C};
   logic [7:0] sa[4] = '{8'h0F, 8'h10, 8'h10, 8'h10};
   logic [7:0] ss[4] = '{8'h00, 8'h00, 8'hFF, 8'h00};

   assign cfg = {display_on_q, cursor_on_q, blink_on_q, entry_inc_q,
      entry_shift_q, graphic_mode_q, power_on_q, bus_width_sel_q};
   assign fnc = {3'h0, two_lines_q, tall_font_q, font_table_hi_q,
      font_table_lo_q, busy_flag_q};

   cdid_core #(.CLEAR_CYC(CLR_CYC)) dut (.clk(clk), .rst(rst), .ce(ce),
      .strobe(strobe), .reg_select(reg_select),
      .read_not_write(read_not_write), .data_in(data_in),
      .data_out_q(data_out_q), .data_valid_q(data_valid_q),
      .busy_flag_q(busy_flag_q),
      .ram_address_counter_q(ram_address_counter_q),
      .display_on_q(display_on_q), .cursor_on_q(cursor_on_q),
      .blink_on_q(blink_on_q), .entry_inc_q(entry_inc_q),
      .entry_shift_q(entry_shift_q), .graphic_mode_q(graphic_mode_q),
      .power_on_q(power_on_q), .bus_width_sel_q(bus_width_sel_q),
      .two_lines_q(two_lines_q), .tall_font_q(tall_font_q),
      .font_table_hi_q(font_table_hi_q), .font_table_lo_q(font_table_lo_q),
      .display_shift_q(display_shift_q), .invalid_q(invalid_q));

   cdid_host_model host (.clk(clk), .busy_flag_q(busy_flag_q),
      .data_valid_q(data_valid_q), .invalid_q(invalid_q),
      .bus_width_sel_q(bus_width_sel_q), .data_out_q(data_out_q),
      .strobe(strobe), .reg_select(reg_select),
      .read_not_write(read_not_write), .data_in(data_in));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic end_sim();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string name, input logic [7:0] exp,
         input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic run(input logic rs, input logic rnw, input logic [7:0] d);
      host.xfer(rs, rnw, d);
      host.wait_ready();
      if (host.timed_out) begin
         failures++;
         $display("CHECK FAILED handshake expected answer seen none");
         end_sim();
      end
   endtask : run

   task automatic cmd(input logic [7:0] d);
      run(1'b0, 1'b0, d);
   endtask : cmd

   task automatic wr(input logic [7:0] d);
      run(1'b1, 1'b0, d);
   endtask : wr

   task automatic stat(input logic [7:0] exp);
      run(1'b0, 1'b1, 8'h00);
      chk("status", exp, host.rd);
   endtask : stat

   task automatic rdd(input logic [7:0] exp);
      run(1'b1, 1'b1, 8'h00);
      chk("ram_read", exp, host.rd);
   endtask : rdd

   initial begin
      failures = 0;
      compares = 0;
      rst = 1'b1;
      ce = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      rst = 1'b0;
      chk("cfg_rst", 8'h11, cfg);
      chk("fnc_rst", 8'h00, fnc);
      // function set fields, every font code
      for (int i = 0; i < 3; i++) begin
         cmd(8'h38 | 8'(i));
         chk("fnc", 8'h10 | 8'(i << 1), fnc);
      end
      cmd(8'h37);
      chk("fnc_bad_font", 8'h0C, fnc);
      // display bits and mode form
      cmd(8'h0D);
      chk("disp", 8'hB1, cfg);
      cmd(8'h0A);
      cmd(8'h1B);
      chk("mode", 8'h55, cfg);
      cmd(8'h17);
      chk("mode", 8'h53, cfg);
      // data writes and reads step the counter
      cmd(8'h90);
      stat(8'h10);
      wr(8'h41);
      wr(8'h42);
      stat(8'h12);
      cmd(8'h90);
      rdd(8'h41);
      stat(8'h11);
      cmd(8'h04);
      wr(8'h43);
      stat(8'h10);
      // cursor and display shifts
      for (int i = 0; i < 4; i++) begin
         cmd(sc[i]);
         chk("shift_ac", sa[i], {1'b0, ram_address_counter_q});
         chk("shift_disp", ss[i], display_shift_q);
      end
      // shift together with display writes
      cmd(8'h07);
      wr(8'h44);
      chk("wr_shift", 8'hFF, display_shift_q);
      cmd(8'h05);
      wr(8'h45);
      chk("wr_shift", 8'h00, display_shift_q);
      stat(8'h10);
      // home keeps ram contents
      cmd(8'h1C);
      cmd(8'h02);
      chk("home_disp", 8'h00, display_shift_q);
      stat(8'h00);
      cmd(8'h90);
      rdd(8'h44);
      // glyph ram
      cmd(8'h06);
      cmd(8'h45);
      wr(8'h1F);
      stat(8'h06);
      cmd(8'h45);
      rdd(8'h1F);
      // clear, with traffic while busy
      cmd(8'h05);
      cmd(8'h1C);
      host.xfer(1'b0, 1'b0, 8'h01);
      host.xfer(1'b0, 1'b1, 8'h00);
      chk("busy_bit", 8'h01, {7'h0, host.rd[7]});
      host.xfer(1'b0, 1'b0, 8'h0F);
      chk("refused", 8'h01, {7'h0, host.refused});
      // frozen enable must stretch the clear past its length
      @(posedge clk);
      #1;
      ce = 1'b0;
      repeat (250) @(posedge clk);
      #1;
      chk("ce_freeze", 8'h01, {7'h0, busy_flag_q});
      ce = 1'b1;
      host.wait_ready();
      chk("clr_cfg", 8'h5B, cfg);
      chk("clr_disp", 8'h00, display_shift_q);
      stat(8'h00);
      cmd(8'h91);
      rdd(8'h20);
      cmd(8'h80);
      rdd(8'h20);
      // narrow bus round trip
      cmd(8'h28);
      chk("bus4", 8'h00, {7'h0, bus_width_sel_q});
      cmd(8'hB0);
      wr(8'h5A);
      cmd(8'h38);
      chk("bus8", 8'h01, {7'h0, bus_width_sel_q});
      cmd(8'hB0);
      rdd(8'h5A);
      end_sim();
   end
endmodule : char_display_instruction_decoder_test
